// ### hw/ext_seq_map.vh
// Constants for the extended sequencer control register bank.
// Assumes an indexed byte port: index latched first, data port at 3C5.
`ifndef EXT_SEQ_MAP_VH
`define EXT_SEQ_MAP_VH
`define IDX_SEQ_MODE 8'h07
`define IDX_EEPROM 8'h08
`define IDX_SCRATCH0 8'h09
`define IDX_SCRATCH1 8'h0a
`define IDX_NUM0 8'h0b
`define IDX_NUM1 8'h0c
`define IDX_NUM2 8'h0d
`define IDX_NUM3 8'h0e
`define IDX_MEMCTL 8'h0f
`define RST_NUM0 7'h66
`define RST_NUM1 7'h5b
`define RST_NUM2 7'h45
`define RST_NUM3 7'h7e
`define DIV_NORMAL 2'h0
`define DIV_BY2 2'h1
`define DIV_BY3 2'h2
`define DIV_PIXRATE 2'h3
`define BUS_W8 2'h0
`define BUS_W16 2'h1
`define BUS_W32 2'h2
`define FIFO_SHALLOW 5'h08
`define FIFO_DEEP 5'h10
`define FIFO_DEEP_ALT 5'h14
`define CHAR_PIX_PACKED 5'h08
`define CHAR_CLK_BY3 5'h18
`endif

// ### hw/ext_seq_regs.v
// Extended sequencer control registers with their decoded control outputs.
// Assumes host index/data strobes are synchronous to clk_sys; pins are not.
`timescale 1ns/1ps
`include "ext_seq_map.vh"
module ext_seq_regs #(
   parameter ALT_MEMBER = 1'b0
) (
   input wire clk_sys,
   input wire nrst,
   input wire clk_en,
   // Host index/data port
   input wire idx_wr,
   input wire [7:0] idx_data,
   input wire data_wr,
   input wire data_rd,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data,
   output reg rd_hit,

   // Board pins and same-clock display timing
   input wire [2:0] config_straps,
   input wire hblank,
   input wire mem_access,
   output reg wide_memory_chip_select,
   input wire eeprom_data_in_pin,
   output reg eeprom_chip_select_pin,
   input wire external_sync_pin_i,
   output reg external_sync_pin_o,
   output reg external_sync_pin_oe,
   input wire external_video_enable_pin_n_i,
   output reg external_video_enable_pin_n_o,
   output reg external_video_enable_pin_n_oe,

   // Decoded controls for the sequencer, cursor and memory
   output reg sync_ctl,
   output reg video_en_ctl_n,
   output reg [1:0] char_div,
   output reg [4:0] char_clk_pixels,
   output reg byte_rate_dac,
   output reg packed_pixel,
   output reg set_reset_off,
   output reg cursor_allowed,
   output reg cursor_pixel_units,
   output reg cursor_dac_only,
   output reg low_byte_pins_only,
   output reg div2_illegal,
   output reg bank_x16,
   output reg second_row_strobe_en,
   output reg random_writes,
   output reg [4:0] fifo_levels,
   output reg [1:0] bus_width,
   output reg [6:0] num0,
   output reg [6:0] num1,
   output reg [6:0] num2,
   output reg [6:0] num3
);
   // Host-visible register state
   reg [7:0] index_q;
   reg [1:0] div_q;
   reg hires_q;
   reg [4:0] ee_low_q;
   reg ee_in_en_q;
   reg latch_q;
   reg suppress_q;
   reg [7:0] scr0_q;
   reg [7:0] scr1_q;
   reg [6:0] n0_q;
   reg [6:0] n1_q;
   reg [6:0] n2_q;
   reg [6:0] n3_q;
   reg bank_q;
   reg nofp_q;
   reg deep_q;
   reg [1:0] bw_pend_q;

   // Strap capture and pin synchronisers
   reg [2:0] strap_s1_q;
   reg [2:0] strap_s2_q;
   reg [1:0] strap_cnt_q;
   reg [2:0] strap_q;
   reg strap_done_q;
   reg [2:0] s1_q;
   reg [2:0] s2_q;

   // Display timing and latched pin levels
   reg hb_prev_q;
   reg sync_lat_q;
   reg vid_lat_q;

   reg [7:0] rd_d;

   // Write strobe, decoded serial memory output enable and hblank start edge
   wire wr = clk_en & data_wr;
   wire ee_oe = ee_low_q[4];
   wire hb_start = hblank & ~hb_prev_q;

   // Index latch; a data strobe in the same cycle still sees the old index
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         index_q <= 8'h00;
      end else if (clk_en && idx_wr) begin
         index_q <= idx_data;
      end
   end

   // Pins from outside pass two flops before use
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
      end else if (clk_en) begin
         s1_q <= {eeprom_data_in_pin, external_sync_pin_i,
            external_video_enable_pin_n_i};
         s2_q <= s1_q;
      end
   end

   // Register writes; unmapped indexes fall through and change nothing
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         div_q <= 2'h0;
         hires_q <= 1'b0;
         ee_low_q <= 5'h00;
         ee_in_en_q <= 1'b0;
         latch_q <= 1'b0;
         suppress_q <= 1'b0;
         scr0_q <= 8'h00;
         scr1_q <= 8'h00;
         n0_q <= `RST_NUM0;
         n1_q <= `RST_NUM1;
         n2_q <= `RST_NUM2;
         n3_q <= `RST_NUM3;
         bank_q <= 1'b0;
         nofp_q <= 1'b0;
         deep_q <= 1'b0;
         bw_pend_q <= 2'h0;
      end else begin
         if (wr) begin
            case (index_q)
               `IDX_SEQ_MODE: begin
                  div_q <= wr_data[2:1];
                  hires_q <= wr_data[0];
               end
               `IDX_EEPROM: begin
                  suppress_q <= wr_data[6];
                  latch_q <= wr_data[5];
                  ee_low_q <= {wr_data[4:2], 1'b0, wr_data[0]};
                  ee_in_en_q <= wr_data[1];
               end
               `IDX_SCRATCH0: begin
                  scr0_q <= wr_data;
               end
               `IDX_SCRATCH1: begin
                  scr1_q <= wr_data;
               end
               `IDX_NUM0: begin
                  n0_q <= wr_data[6:0];
               end
               `IDX_NUM1: begin
                  n1_q <= wr_data[6:0];
               end
               `IDX_NUM2: begin
                  n2_q <= wr_data[6:0];
               end
               `IDX_NUM3: begin
                  n3_q <= wr_data[6:0];
               end
               `IDX_MEMCTL: begin
                  bank_q <= wr_data[7];
                  nofp_q <= wr_data[6];
                  deep_q <= wr_data[5];
                  bw_pend_q <= wr_data[4:3];
               end
               default: ;
            endcase
         end
      end
   end

   // ee_low_q layout: [4] output enable, [3] data out, [2] serial clock,
   // [1] unused, [0] chip select
   wire ee_cs = ee_low_q[0];
   wire ee_sk = ee_low_q[2];
   wire ee_do = ee_low_q[3];

   // Straps are board pins: two flops, then one capture after reset.
   // The capture waits until the second stage holds a real pin level.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
         strap_cnt_q <= 2'h0;
         strap_q <= 3'h0;
         strap_done_q <= 1'b0;
      end else if (clk_en) begin
         strap_s1_q <= config_straps;
         strap_s2_q <= strap_s1_q;
         if (!strap_done_q) begin
            if (strap_cnt_q == 2'h2) begin
               strap_q <= strap_s2_q;
               strap_done_q <= 1'b1;
            end else begin
               strap_cnt_q <= strap_cnt_q + 2'h1;
            end
         end
      end
   end

   // Read mux; reserved bits and unmapped indexes read zero
   always @* begin
      rd_d = 8'h00;
      case (index_q)
         `IDX_SEQ_MODE: rd_d = {4'h0, 1'b0, div_q, hires_q};
         `IDX_EEPROM: rd_d = {ee_in_en_q & s2_q[2],
            suppress_q, latch_q, ee_oe, ee_do, ee_sk, ee_in_en_q, ee_cs};
         `IDX_SCRATCH0: rd_d = scr0_q;
         `IDX_SCRATCH1: rd_d = scr1_q;
         `IDX_NUM0: rd_d = {1'b0, n0_q};
         `IDX_NUM1: rd_d = {1'b0, n1_q};
         `IDX_NUM2: rd_d = {1'b0, n2_q};
         `IDX_NUM3: rd_d = {1'b0, n3_q};
         `IDX_MEMCTL: rd_d = {bank_q, nofp_q, deep_q, bw_pend_q,
            strap_q};
         default: rd_d = 8'h00;
      endcase
   end

   // Read answer stands for one cycle, zero otherwise
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_data <= 8'h00;
         rd_hit <= 1'b0;
      end else if (clk_en) begin
         if (data_rd) begin
            rd_data <= rd_d;
         end else begin
            rd_data <= 8'h00;
         end
         rd_hit <= data_rd;
      end
   end

   // Double buffer: pending width loads at hblank start so timing never shifts mid scanline
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hb_prev_q <= 1'b0;
         bus_width <= `BUS_W8;
      end else if (clk_en) begin
         hb_prev_q <= hblank;
         if (hb_start) begin
            bus_width <= bw_pend_q;
         end
      end
   end

   // Latch bit 0: follow pins; 1: hold last captured level
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync_lat_q <= 1'b0;
         vid_lat_q <= 1'b1;
         sync_ctl <= 1'b0;
         video_en_ctl_n <= 1'b1;
      end else if (clk_en) begin
         if (!latch_q) begin
            sync_lat_q <= s2_q[1];
            vid_lat_q <= s2_q[0];
            sync_ctl <= s2_q[1];
            video_en_ctl_n <= s2_q[0];
         end else begin
            sync_ctl <= sync_lat_q;
            video_en_ctl_n <= vid_lat_q;
         end
      end
   end

   // Pins shared with the serial memory; enables high while driving.
   // Software must latch the pin levels first or the display glitches.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wide_memory_chip_select <= 1'b0;
         eeprom_chip_select_pin <= 1'b0;
         external_sync_pin_o <= 1'b0;
         external_sync_pin_oe <= 1'b0;
         external_video_enable_pin_n_o <= 1'b1;
         external_video_enable_pin_n_oe <= 1'b0;
      end else if (clk_en) begin
         wide_memory_chip_select <= mem_access & ~suppress_q;
         eeprom_chip_select_pin <= ee_cs;
         external_sync_pin_o <= ee_sk;
         external_sync_pin_oe <= ee_oe;
         external_video_enable_pin_n_o <= ee_do;
         external_video_enable_pin_n_oe <= ee_oe;
      end
   end

   // Character clock modes
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         char_div <= `DIV_NORMAL;
         char_clk_pixels <= 5'h00;
         byte_rate_dac <= 1'b0;
         packed_pixel <= 1'b0;
         set_reset_off <= 1'b0;
         low_byte_pins_only <= 1'b0;
      end else if (clk_en) begin
         char_div <= div_q;
         byte_rate_dac <= div_q == `DIV_BY3;
         if (div_q == `DIV_BY3) begin
            char_clk_pixels <= `CHAR_CLK_BY3;
         end else if (hires_q) begin
            char_clk_pixels <= `CHAR_PIX_PACKED;
         end else begin
            char_clk_pixels <= 5'h00;
         end
         packed_pixel <= hires_q;
         set_reset_off <= hires_q & ALT_MEMBER;
         low_byte_pins_only <= div_q == `DIV_PIXRATE;
      end
   end

   // Cursor limits follow the divider
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cursor_allowed <= 1'b1;
         cursor_pixel_units <= 1'b0;
         cursor_dac_only <= 1'b0;
         div2_illegal <= 1'b0;
      end else if (clk_en) begin
         cursor_allowed <= div_q != `DIV_BY3;
         cursor_pixel_units <= div_q == `DIV_BY2;
         cursor_dac_only <= div_q == `DIV_BY2;
         // Divide-by-two only valid on the widest memory path
         if (div_q == `DIV_BY2 && bus_width != `BUS_W32) begin
            div2_illegal <= 1'b1;
         end else begin
            div2_illegal <= 1'b0;
         end
      end
   end

   // Memory layout controls
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bank_x16 <= 1'b0;
         second_row_strobe_en <= 1'b0;
         random_writes <= 1'b0;
         fifo_levels <= `FIFO_SHALLOW;
      end else if (clk_en) begin
         bank_x16 <= bank_q;
         second_row_strobe_en <= bank_q;
         random_writes <= nofp_q;
         if (!deep_q) begin
            fifo_levels <= `FIFO_SHALLOW;
         end else if (ALT_MEMBER) begin
            fifo_levels <= `FIFO_DEEP_ALT;
         end else begin
            fifo_levels <= `FIFO_DEEP;
         end
      end
   end

   // Numerators mirrored to the clock synthesiser; bit 7 is never stored
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         num0 <= `RST_NUM0;
         num1 <= `RST_NUM1;
         num2 <= `RST_NUM2;
         num3 <= `RST_NUM3;
      end else if (clk_en) begin
         num0 <= n0_q;
         num1 <= n1_q;
         num2 <= n2_q;
         num3 <= n3_q;
      end
   end
endmodule

// ### tb/ext_seq_checker.sv
// Port assertions for the extended sequencer register bank.
// Assumes one clock domain and the default family member.
`timescale 1ns/1ps
module ext_seq_checker (
   input wire clk_sys,
   input wire nrst,
   input wire clk_en,
   input wire data_rd,
   input wire rd_hit,
   input wire mem_access,
   input wire wide_memory_chip_select,
   input wire external_sync_pin_oe,
   input wire external_video_enable_pin_n_oe,
   input wire [1:0] char_div,
   input wire [4:0] char_clk_pixels,
   input wire byte_rate_dac,
   input wire cursor_allowed,
   input wire cursor_pixel_units,
   input wire cursor_dac_only,
   input wire low_byte_pins_only,
   input wire bank_x16,
   input wire second_row_strobe_en,
   input wire [4:0] fifo_levels
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_req; data_rd && clk_en; endsequence
   property p_rd; s_req |=> rd_hit; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_wcs; !mem_access |=> !wide_memory_chip_select; endproperty
   a_wcs: assert property (p_wcs) else $error("stray chip select");
   property p_oe;
      external_sync_pin_oe == external_video_enable_pin_n_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("pin enables differ");
   property p_div3;
      char_div == 2'h2 |-> char_clk_pixels == 5'h18 && byte_rate_dac
         && !cursor_allowed;
   endproperty
   a_div3: assert property (p_div3) else $error("div3 mode");
   property p_div2;
      char_div == 2'h1 |-> cursor_pixel_units && cursor_dac_only;
   endproperty
   a_div2: assert property (p_div2) else $error("div2 cursor");
   property p_pix; char_div == 2'h3 |-> low_byte_pins_only; endproperty
   a_pix: assert property (p_pix) else $error("pixel rate mode");
   property p_bank; bank_x16 == second_row_strobe_en; endproperty
   a_bank: assert property (p_bank) else $error("bank strobe");
   property p_fifo; fifo_levels inside {5'h08, 5'h10}; endproperty
   a_fifo: assert property (p_fifo) else $error("fifo depth");
endmodule
bind ext_seq_regs ext_seq_checker chk (
   .clk_sys(clk_sys),
   .nrst(nrst),
   .clk_en(clk_en),
   .data_rd(data_rd),
   .rd_hit(rd_hit),
   .mem_access(mem_access),
   .wide_memory_chip_select(wide_memory_chip_select),
   .external_sync_pin_oe(external_sync_pin_oe),
   .external_video_enable_pin_n_oe(external_video_enable_pin_n_oe),
   .char_div(char_div),
   .char_clk_pixels(char_clk_pixels),
   .byte_rate_dac(byte_rate_dac),
   .cursor_allowed(cursor_allowed),
   .cursor_pixel_units(cursor_pixel_units),
   .cursor_dac_only(cursor_dac_only),
   .low_byte_pins_only(low_byte_pins_only),
   .bank_x16(bank_x16),
   .second_row_strobe_en(second_row_strobe_en),
   .fifo_levels(fifo_levels)
);

// ### tb/eeprom_pin_model.sv
// Board side of the shared sync/video-enable pins and memory data line.
// Assumes the board pulls sync high and video-enable low when released.
`timescale 1ns/1ps
module eeprom_pin_model (
   input wire din_lvl,
   input wire sync_o,
   input wire sync_oe,
   input wire vid_o,
   input wire vid_oe,
   output wire sync_i,
   output wire vid_i,
   output wire din
);
   // Released pins show the board level, never the last driven value
   assign sync_i = sync_oe ? sync_o : 1'b1;
   assign vid_i = vid_oe ? vid_o : 1'b0;
   assign din = din_lvl;
endmodule

// ### tb/extended_sequencer_control_regs_tb_top.sv
// Register-level tests of the extended sequencer bank.
// Assumes the bank is driven alone through its index/data strobes.
`timescale 1ns/1ps
module extended_sequencer_control_regs_tb_top;
   reg clk_sys = 0, nrst = 0, clk_en = 1, idx_wr = 0, data_wr = 0;
   reg data_rd = 0, hblank = 0, mem_access = 0, din_lvl = 1;
   reg [7:0] idx_data = 8'h00, wr_data = 8'h00;
   reg [2:0] config_straps = 3'h5;
   wire [7:0] rd_data;
   wire [4:0] char_clk_pixels, fifo_levels;
   wire [1:0] char_div, bus_width;
   wire [6:0] num0, num1, num2, num3;
   wire rd_hit, wide_memory_chip_select, eeprom_data_in_pin;
   wire eeprom_chip_select_pin, sync_ctl, video_en_ctl_n;
   wire external_sync_pin_i, external_sync_pin_o, external_sync_pin_oe;
   wire external_video_enable_pin_n_i, external_video_enable_pin_n_o;
   wire external_video_enable_pin_n_oe, byte_rate_dac, packed_pixel;
   wire set_reset_off, cursor_allowed, cursor_pixel_units, cursor_dac_only;
   wire low_byte_pins_only, div2_illegal, bank_x16, second_row_strobe_en;
   wire random_writes;
   integer fails = 0, num_checks = 0, k;
   always #25 clk_sys = ~clk_sys;
   ext_seq_regs uut (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clk_en(clk_en),
      .idx_wr(idx_wr),
      .idx_data(idx_data),
      .data_wr(data_wr),
      .data_rd(data_rd),
      .wr_data(wr_data),
      .rd_data(rd_data),
      .rd_hit(rd_hit),
      .config_straps(config_straps),
      .hblank(hblank),
      .mem_access(mem_access),
      .wide_memory_chip_select(wide_memory_chip_select),
      .eeprom_data_in_pin(eeprom_data_in_pin),
      .eeprom_chip_select_pin(eeprom_chip_select_pin),
      .external_sync_pin_i(external_sync_pin_i),
      .external_sync_pin_o(external_sync_pin_o),
      .external_sync_pin_oe(external_sync_pin_oe),
      .external_video_enable_pin_n_i(external_video_enable_pin_n_i),
      .external_video_enable_pin_n_o(external_video_enable_pin_n_o),
      .external_video_enable_pin_n_oe(external_video_enable_pin_n_oe),
      .sync_ctl(sync_ctl),
      .video_en_ctl_n(video_en_ctl_n),
      .char_div(char_div),
      .char_clk_pixels(char_clk_pixels),
      .byte_rate_dac(byte_rate_dac),
      .packed_pixel(packed_pixel),
      .set_reset_off(set_reset_off),
      .cursor_allowed(cursor_allowed),
      .cursor_pixel_units(cursor_pixel_units),
      .cursor_dac_only(cursor_dac_only),
      .low_byte_pins_only(low_byte_pins_only),
      .div2_illegal(div2_illegal),
      .bank_x16(bank_x16),
      .second_row_strobe_en(second_row_strobe_en),
      .random_writes(random_writes),
      .fifo_levels(fifo_levels),
      .bus_width(bus_width),
      .num0(num0),
      .num1(num1),
      .num2(num2),
      .num3(num3)
   );
   eeprom_pin_model far (.din_lvl(din_lvl), .sync_o(external_sync_pin_o),
      .sync_oe(external_sync_pin_oe), .vid_o(external_video_enable_pin_n_o),
      .vid_oe(external_video_enable_pin_n_oe), .sync_i(external_sync_pin_i),
      .vid_i(external_video_enable_pin_n_i), .din(eeprom_data_in_pin));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] i, input [7:0] d);
      begin
         @(negedge clk_sys);
         idx_wr = 1;
         idx_data = i;
         @(negedge clk_sys);
         idx_wr = 0;
         data_wr = 1;
         wr_data = d;
         @(negedge clk_sys);
         data_wr = 0;
         @(negedge clk_sys);
      end
   endtask
   task rd(input [7:0] i, input [7:0] e);
      begin
         @(negedge clk_sys);
         idx_wr = 1;
         idx_data = i;
         @(negedge clk_sys);
         idx_wr = 0;
         data_rd = 1;
         @(negedge clk_sys);
         data_rd = 0;
         chk(rd_data, e);
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      #200000;
      fails = fails + 1;
      close_out;
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      nrst = 1;
      rd(8'h0b, 8'h66);
      rd(8'h0c, 8'h5b);
      rd(8'h0d, 8'h45);
      rd(8'h0e, 8'h7e);
      chk({1'b0, num0}, 8'h66);
      chk({1'b0, num1}, 8'h5b);
      chk({1'b0, num2}, 8'h45);
      chk({1'b0, num3}, 8'h7e);
      rd(8'h0a, 8'h00);
      rd(8'h0f, 8'h05);
      wr(8'h09, 8'ha5);
      rd(8'h09, 8'ha5);
      wr(8'h0e, 8'hff);
      rd(8'h0e, 8'h7f);
      chk({1'b0, num3}, 8'h7f);
      wr(8'h20, 8'hff);
      rd(8'h20, 8'h00);
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'h07, {5'h00, k[1:0], 1'b0});
         chk({6'h00, char_div}, k[7:0]);
         chk({3'h0, cursor_allowed, cursor_pixel_units, cursor_dac_only,
            low_byte_pins_only, byte_rate_dac}, (k == 0) ? 8'h10 :
            (k == 1) ? 8'h1c : (k == 2) ? 8'h01 : 8'h12);
         chk({7'h00, div2_illegal}, (k == 1) ? 8'h01 : 8'h00);
      end
      wr(8'h07, 8'h0f);
      rd(8'h07, 8'h07);
      chk({2'h0, packed_pixel, char_clk_pixels}, 8'h28);
      chk({7'h00, set_reset_off}, 8'h00);
      chk({6'h00, sync_ctl, video_en_ctl_n}, 8'h02);
      wr(8'h08, 8'h20);
      wr(8'h08, 8'h35);
      chk({4'h0, eeprom_chip_select_pin, external_sync_pin_oe,
         external_sync_pin_o, external_video_enable_pin_n_o}, 8'h0e);
      wr(8'h08, 8'h2a);
      rd(8'h08, 8'haa);
      wr(8'h08, 8'h20);
      rd(8'h08, 8'h20);
      wr(8'h08, 8'h00);
      mem_access = 1;
      wr(8'h08, 8'h40);
      chk({7'h00, wide_memory_chip_select}, 8'h00);
      wr(8'h08, 8'h00);
      chk({7'h00, wide_memory_chip_select}, 8'h01);
      wr(8'h0f, 8'hf7);
      chk({bank_x16, second_row_strobe_en, random_writes, fifo_levels},
         8'hf0);
      chk({6'h00, bus_width}, 8'h00);
      hblank = 1;
      repeat (3) @(negedge clk_sys);
      chk({6'h00, bus_width}, 8'h02);
      hblank = 0;
      rd(8'h0f, 8'hf5);
      wr(8'h0f, 8'h08);
      chk({7'h00, random_writes}, 8'h00);
      close_out;
   end
endmodule
